// ==== hw/tbr_pkg.sv ====
// Shared constants and carrier types for the telemetry bit randomizer
package tbr_pkg;

  // ------------------------------------------------------------------
  // Self-synchronizing descrambler
  // ------------------------------------------------------------------
  localparam int          SS_LEN     = 15;    // Register stages
  localparam int          SS_TAP_A   = 14;    // First tapped stage
  localparam int          SS_TAP_B   = 15;    // Second tapped stage
  localparam logic [3:0]  SS_SETTLE  = 4'hf;  // Clean bits before output trusted
  localparam logic [3:0]  SS_CNT_ONE = 4'h1;
  localparam logic [3:0]  SS_CNT_RST = 4'h0;

  // ------------------------------------------------------------------
  // Block sequence generator, x^8 + x^7 + x^5 + x^3 + 1
  // ------------------------------------------------------------------
  localparam int          BLK_LEN    = 8;
  localparam logic [7:0]  BLK_SEED   = 8'hff;  // All ones at block start
  localparam logic [7:0]  BLK_TAPS   = 8'ha9;  // Feedback taps, stages 0,3,5,7
  localparam logic [7:0]  BLK_AFTER8 = 8'h12;  // State after eight advances
  localparam int          BLK_PERIOD = 255;

  // ------------------------------------------------------------------
  // Buffering
  // ------------------------------------------------------------------
  localparam int          FIFO_DEPTH = 32;

  // One output bit with its qualifiers
  typedef struct packed {
    logic data;     // Descrambled bit
    logic trusted;  // Bit is valid
    logic marker;   // Bit belongs to the block sync marker
  } tbr_word_s;

  localparam int          WORD_W     = $bits(tbr_word_s);

endpackage

// ==== hw/tbr_randomizer.sv ====
// Telemetry bit descrambler core with clock-crossing output FIFO
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Asynchronous FIFO, gray-coded pointers
// ------------------------------------------------------------------
module tbr_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 32
) (
  // Write side
  input  wire logic             wr_clk_in,
  input  wire logic             wr_rst_n_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Read side
  input  wire logic             rd_clk_in,
  input  wire logic             rd_rst_n_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin;
  logic [AW:0]      next_wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      next_rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      rgray_s1;
  logic [AW:0]      rgray_s2;
  logic [AW:0]      wgray_s1;
  logic [AW:0]      wgray_s2;
  logic             push;
  logic             pop;

  // Full when write gray is read gray with top two bits inverted
  always_comb begin
    wr_ready_out = (wgray != {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]});
    rd_valid_out = (rgray != wgray_s2);
    rd_data_out  = mem[rbin[AW-1:0]];
    push         = wr_valid_in && wr_ready_out;
    pop          = rd_valid_out && rd_ready_in;
    next_wbin    = wbin + {{AW{1'b0}}, push};
    next_rbin    = rbin + {{AW{1'b0}}, pop};
  end

  // Write domain: pointer, storage, read pointer synchroniser
  always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
    if (!wr_rst_n_in) begin
      wbin     <= '0;
      wgray    <= '0;
      rgray_s1 <= '0;
      rgray_s2 <= '0;
    end else begin
      wbin     <= next_wbin;
      wgray    <= next_wbin ^ (next_wbin >> 1);
      rgray_s1 <= rgray;
      rgray_s2 <= rgray_s1;
    end
  end

  // Storage has no reset; contents are only read once written
  always_ff @(posedge wr_clk_in) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data_in;
    end
  end

  // Read domain: pointer and write pointer synchroniser
  always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
    if (!rd_rst_n_in) begin
      rbin     <= '0;
      rgray    <= '0;
      wgray_s1 <= '0;
      wgray_s2 <= '0;
    end else begin
      rbin     <= next_rbin;
      rgray    <= next_rbin ^ (next_rbin >> 1);
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
    end
  end
endmodule

// ------------------------------------------------------------------
// Descrambler core
// ------------------------------------------------------------------
module tbr_randomizer_core (
  // Reference clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  // Link side, on the recovered bit clock
  input  wire logic             bit_clk_in,
  input  wire logic             ser_bit_in,
  input  wire logic             slip_in,
  input  wire logic             block_mode_in,
  input  wire logic             marker_bit_in,
  input  wire logic             block_lock_in,
  output logic                  link_ready_out,
  // User side, on the reference clock
  output logic                  out_valid_out,
  output tbr_pkg::tbr_word_s    out_word_out,
  input  wire logic             out_ready_in
);
  // ----------------------------------------------------------------
  // Link-domain reset release
  // ----------------------------------------------------------------
  logic [1:0]                    lk_rst_sync;
  logic                          lk_rst_n;

  // Assert at once, release two bit-clock edges later
  always_ff @(posedge bit_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lk_rst_sync <= 2'h0;
    end else begin
      lk_rst_sync <= {lk_rst_sync[0], 1'b1};
    end
  end
  assign lk_rst_n = lk_rst_sync[1];

  // ----------------------------------------------------------------
  // Link-domain descrambling
  // ----------------------------------------------------------------
  logic [tbr_pkg::SS_LEN-1:0]    ss_sr;
  logic [tbr_pkg::SS_LEN-1:0]    next_ss_sr;
  logic [3:0]                    ss_cnt;
  logic [3:0]                    next_ss_cnt;
  logic [tbr_pkg::BLK_LEN-1:0]   lfsr;
  logic [tbr_pkg::BLK_LEN-1:0]   next_lfsr;
  tbr_pkg::tbr_word_s            word;
  tbr_pkg::tbr_word_s            next_word;
  logic                          word_vld;
  logic                          next_word_vld;
  logic                          fifo_wr_ready;
  logic                          marker;
  logic                          ss_key;

  // Stage k of the register is ss_sr[k-1]; newest bit enters stage 1
  always_comb begin
    marker        = block_mode_in && marker_bit_in;
    ss_key        = ss_sr[tbr_pkg::SS_TAP_A-1] ^ ss_sr[tbr_pkg::SS_TAP_B-1];
    next_ss_sr    = {ss_sr[tbr_pkg::SS_LEN-2:0], ser_bit_in};
    next_word_vld = 1'b1;
    next_lfsr     = lfsr;
    next_word     = '0;
    // Slip or block mode restarts the settle count; this bit is the first
    if (slip_in || block_mode_in) begin
      next_ss_cnt = tbr_pkg::SS_CNT_ONE;
    end else if (ss_cnt != tbr_pkg::SS_SETTLE) begin
      next_ss_cnt = ss_cnt + tbr_pkg::SS_CNT_ONE;
    end else begin
      next_ss_cnt = ss_cnt;
    end
    if (!block_mode_in) begin
      // Error spread of 3 and +15 burst span follow from the two taps
      next_word.data    = ser_bit_in ^ ss_key;
      next_word.trusted = (ss_cnt == tbr_pkg::SS_SETTLE) && !slip_in;
    end else if (marker) begin
      // Marker passes clear; generator reloads and waits for data
      next_word.data    = ser_bit_in;
      next_word.marker  = 1'b1;
      next_word.trusted = block_lock_in;
      next_lfsr         = tbr_pkg::BLK_SEED;
    end else if (block_lock_in) begin
      // Purely additive: no memory of past input, so no error spread
      next_word.data    = ser_bit_in ^ lfsr[0];
      next_word.trusted = 1'b1;
      next_lfsr = {^(lfsr & tbr_pkg::BLK_TAPS), lfsr[tbr_pkg::BLK_LEN-1:1]};
    end else begin
      // No marker located yet: pass raw bits, untrusted
      next_word.data    = ser_bit_in;
      next_lfsr         = tbr_pkg::BLK_SEED;
    end
  end

  // Link-domain registers
  always_ff @(posedge bit_clk_in or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      ss_sr          <= '0;
      ss_cnt         <= tbr_pkg::SS_CNT_RST;
      lfsr           <= tbr_pkg::BLK_SEED;
      word           <= '0;
      word_vld       <= 1'b0;
      link_ready_out <= 1'b0;
    end else begin
      ss_sr          <= next_ss_sr;
      ss_cnt         <= next_ss_cnt;
      lfsr           <= next_lfsr;
      word           <= next_word;
      word_vld       <= next_word_vld;
      link_ready_out <= fifo_wr_ready;
    end
  end

  // ----------------------------------------------------------------
  // Clock crossing buffer
  // ----------------------------------------------------------------
  logic                          rd_valid;
  logic                          rd_ready;
  logic [tbr_pkg::WORD_W-1:0]    rd_data;

  // A link bit is lost if the FIFO is full; link_ready_out warns of it
  tbr_fifo #(
    .WIDTH (tbr_pkg::WORD_W),
    .DEPTH (tbr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_in    (bit_clk_in),
    .wr_rst_n_in  (lk_rst_n),
    .wr_valid_in  (word_vld),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (word),
    .rd_clk_in    (ref_clk_in),
    .rd_rst_n_in  (reset_n_in),
    .rd_valid_out (rd_valid),
    .rd_ready_in  (rd_ready),
    .rd_data_out  (rd_data)
  );

  // ----------------------------------------------------------------
  // User-side output register
  // ----------------------------------------------------------------
  logic                          next_out_valid;
  tbr_pkg::tbr_word_s            next_out_word;

  // Reload when empty or when the consumer takes the current word
  always_comb begin
    rd_ready       = !out_valid_out || out_ready_in;
    next_out_valid = out_valid_out;
    next_out_word  = out_word_out;
    if (rd_ready) begin
      next_out_valid = rd_valid;
      next_out_word  = rd_data;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_valid_out <= 1'b0;
      out_word_out  <= '0;
    end else begin
      out_valid_out <= next_out_valid;
      out_word_out  <= next_out_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ss_xor;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    (word.trusted && !$past(block_mode_in)) |->
      (word.data == ($past(ser_bit_in, 1) ^ $past(ser_bit_in, 15) ^ $past(ser_bit_in, 16)));
  endproperty
  a_ss_xor: assert property (p_ss_xor) else $error("self-sync output not in^d14^d15");

  // Run of clean self-sync bits before this one, saturating; long runs stay cheap
  logic [3:0]                    chk_run;
  logic [3:0]                    next_chk_run;
  always_comb begin
    next_chk_run = chk_run;
    if (block_mode_in || slip_in) begin
      next_chk_run = tbr_pkg::SS_CNT_RST;
    end else if (chk_run != tbr_pkg::SS_SETTLE) begin
      next_chk_run = chk_run + tbr_pkg::SS_CNT_ONE;
    end
  end

  // Run counter register, cleared with the link logic
  always_ff @(posedge bit_clk_in or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      chk_run <= tbr_pkg::SS_CNT_RST;
    end else begin
      chk_run <= next_chk_run;
    end
  end

  property p_ss_settle;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    (chk_run == tbr_pkg::SS_SETTLE && !block_mode_in && !slip_in) |=> word.trusted;
  endproperty
  a_ss_settle: assert property (p_ss_settle) else $error("output not trusted after 15 bits");

  property p_ss_slip;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    slip_in |=> (!word.trusted)[*8];
  endproperty
  a_ss_slip: assert property (p_ss_slip) else $error("output trusted too soon after slip");

  property p_blk_seed;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    marker |=> (lfsr == tbr_pkg::BLK_SEED);
  endproperty
  a_blk_seed: assert property (p_blk_seed) else $error("generator not all ones after marker");

  property p_blk_marker;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    marker |=> (word.marker && word.data == $past(ser_bit_in));
  endproperty
  a_blk_marker: assert property (p_blk_marker) else $error("marker bit altered");

  property p_blk_first;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    (marker ##1 (block_mode_in && block_lock_in && !marker_bit_in)) |=>
      (word.data == !$past(ser_bit_in));
  endproperty
  a_blk_first: assert property (p_blk_first) else $error("first data bit not XOR 1");

  property p_blk_seq;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    (marker ##1 (block_mode_in && block_lock_in && !marker_bit_in)[*8]) |=>
      (lfsr == tbr_pkg::BLK_AFTER8);
  endproperty
  a_blk_seq: assert property (p_blk_seq) else $error("sequence after 8 bits wrong");

  property p_one_per_clk;
    @(posedge bit_clk_in) disable iff (!lk_rst_n)
    lk_rst_n |=> word_vld;
  endproperty
  a_one_per_clk: assert property (p_one_per_clk) else $error("bit not taken this clock");
endmodule

// ==== verif/tb_telemetry_bit_randomizer.sv ====
// Self-checking bench for the descrambler core and its output FIFO
`timescale 1ns/100ps
module tb_telemetry_bit_randomizer;
  // --------------------------------------------------------------
  // Signals and counters
  // --------------------------------------------------------------
  logic               ref_clk   = 1'b0;
  logic               reset_n   = 1'b0;
  logic               out_ready = 1'b0;
  logic               bit_clk;
  logic               ser_bit;
  logic               slip;
  logic               mode;
  logic               marker;
  logic               lock;
  logic               link_ready;
  logic               out_valid;
  tbr_pkg::tbr_word_s out_word;
  tbr_pkg::tbr_word_s e;
  logic               chk_on    = 1'b1;
  int                 rdy_mode  = 0;
  int                 n_fail    = 0;
  int                 cmp_count = 0;
  int                 n_drain   = 0;
  int                 cyc       = 0;

  always #12.5 ref_clk = ~ref_clk;

  tbr_link_model u_link (.rst_n_in(reset_n), .bit_clk_out(bit_clk), .ser_bit_out(ser_bit),
    .slip_out(slip), .mode_out(mode), .marker_out(marker), .lock_out(lock));

  tbr_randomizer_core u_dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .bit_clk_in(bit_clk),
    .ser_bit_in(ser_bit), .slip_in(slip), .block_mode_in(mode), .marker_bit_in(marker),
    .block_lock_in(lock), .link_ready_out(link_ready), .out_valid_out(out_valid),
    .out_word_out(out_word), .out_ready_in(out_ready));

  task automatic check(input string what, input logic exp, input logic seen);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic put(input logic b, input logic s, input logic m, input logic k, input logic l);
    u_link.stim_q.push_back({b, s, m, k, l});
  endtask

  // Consumer readiness, random by default; hang guard
  always @(posedge ref_clk) begin
    out_ready <= (rdy_mode == 0) ? 1'($urandom) : (rdy_mode == 2);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // Each word taken while chk_on is set is checked against the oldest expectation
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (!chk_on) begin
        n_drain++;
      end else if (u_link.exp_q.size() == 0) begin
        check("spare word", 1'b0, 1'b1);
      end else begin
        e = u_link.exp_q.pop_front();
        if (e.trusted) check("data", e.data, out_word.data);
        check("trusted", e.trusted, out_word.trusted);
        check("marker", e.marker, out_word.marker);
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h9090));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Self-sync stream, second slip lands before the first has settled
    for (int i = 0; i < 200; i++) put(1'($urandom), i == 90 || i == 98, 1'b0, 1'b0, 1'b0);
    // Block mode: unlocked bits, then two marked blocks, the second with all-zero data
    for (int i = 0; i < 10; i++) put(1'($urandom), 1'b0, 1'b1, 1'b0, 1'b0);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 32; i++) put(1'($urandom), 1'b0, 1'b1, 1'b1, 1'b1);
      for (int i = 0; i < (b == 0 ? 300 : 40); i++) begin
        put(b == 0 ? 1'($urandom) : 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      end
    end
    for (int k = 0; k < 9000 && u_link.stim_q.size() != 0; k++) @(posedge ref_clk);
    // Short stall must not reach the refusal point
    rdy_mode <= 1;
    repeat (100) @(posedge ref_clk);
    check("link ready in stall", 1'b1, link_ready);
    rdy_mode <= 0;
    u_link.run <= 1'b0;
    for (int k = 0; k < 2000 && u_link.exp_q.size() > 1; k++) @(posedge ref_clk);
    // Long stall fills the buffer, then drain it empty
    rdy_mode <= 1;
    u_link.run <= 1'b1;
    repeat (400) @(posedge ref_clk);
    check("link ready when full", 1'b0, link_ready);
    u_link.run <= 1'b0;
    chk_on <= 1'b0;
    rdy_mode <= 2;
    repeat (200) @(posedge ref_clk);
    check("valid after drain", 1'b0, out_valid);
    check("words held", 1'b1, n_drain >= tbr_pkg::FIFO_DEPTH);
    print_verdict();
  end
endmodule

// ==== verif/tbr_link_model.sv ====
// Far-side model: bit synchronizer and framer feeding the link, with reference
`timescale 1ns/100ps
module tbr_link_model (
  // Reset
  input  wire logic rst_n_in,
  // Link lines
  output logic      bit_clk_out,
  output logic      ser_bit_out,
  output logic      slip_out,
  output logic      mode_out,
  output logic      marker_out,
  output logic      lock_out
);
  // --------------------------------------------------------------
  // Queues and reference state
  // --------------------------------------------------------------
  logic [4:0]         stim_q[$];
  // Stream stands for data after any LDPC decode, so no spread reaches a decoder
  tbr_pkg::tbr_word_s exp_q[$];
  localparam logic [39:0] SEQ40 = 40'hff480ec09a;  // Fixed start of the block sequence
  int                 bi  = 0;
  logic               pb;
  tbr_pkg::tbr_word_s w;
  logic               run = 1'b1;
  int                 pre = 0;
  int                 cnt = 0;
  logic [14:0]        sr  = 15'h0000;
  logic [7:0]         seq = 8'hff;

  initial {bit_clk_out, ser_bit_out, slip_out, mode_out, marker_out, lock_out} = 6'h00;

  // Bits change on the falling edge; the clock stands still while stopped.
  // First rising edge falls inside the bench reset so the link sync clears.
  always begin
    #40 bit_clk_out = 1'b1;
    #80 bit_clk_out = 1'b0;
    while (!run) begin
      #10 ser_bit_out = ~ser_bit_out;  // Never a stale level between frames
    end
    if (pre == 2 && stim_q.size() != 0) begin
      {ser_bit_out, slip_out, mode_out, marker_out, lock_out} = stim_q.pop_front();
    end else begin
      ser_bit_out = 1'($urandom);  // Idle fill keeps mode and lock
      slip_out    = 1'b0;
      marker_out  = 1'b0;
    end
    #40;
  end

  // One expected word per bit taken, after the two sync edges
  always @(posedge bit_clk_out or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre = 0;
      cnt = 0;
      sr  = 15'h0000;
      seq = 8'hff;
    end else if (pre < 2) begin
      pre++;
    end else begin
      if (!mode_out) begin
        if (slip_out) cnt = 0;
        w = {ser_bit_out ^ sr[13] ^ sr[14], cnt >= 15, 1'b0};
        sr = {sr[13:0], ser_bit_out};
        if (cnt < 15) cnt++;
      end else if (marker_out) begin
        cnt = 0;
        bi  = 0;
        w   = {ser_bit_out, lock_out, 1'b1};
        seq = 8'hff;
      end else if (lock_out) begin
        cnt = 0;
        // First 40 bits of a block from the fixed pattern, not the polynomial
        pb  = (bi < 40) ? SEQ40[39-bi] : seq[0];
        w   = {ser_bit_out ^ pb, 1'b1, 1'b0};
        if (bi < 40) bi++;
        seq = {seq[7] ^ seq[5] ^ seq[3] ^ seq[0], seq[7:1]};
      end else begin
        cnt = 0;
        w   = {ser_bit_out, 1'b0, 1'b0};
        seq = 8'hff;
      end
      exp_q.push_back(w);
    end
  end
endmodule
